// *** verilog/ctas_top.sv ***
/*
  Transmit abort, automatic block transmit pointer and sleep mode control,
  with a history FIFO of successfully sent buffer numbers, except buffers 0 to 7 in ABT mode.
  Assumes the protocol engine runs on clk, reports completions through a
  one-cycle done pulse and raises tx_busy while a frame is on the bus.
  The receive pin is asynchronous. clk itself must keep running in sleep
  so the wake edge can be seen; clk_run gates the rest of the controller.
*/
`timescale 1ns/1ps

module ctas_fifo
  import ctas_pkg::*;
#(
  parameter int W = 4,
  parameter int D = 32
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);

  initial begin
    if (D < 2 || (1 << AW) != D || W < 1) begin
      $error("ctas_fifo: depth must be a power of two");
    end
  end

  logic [W-1:0] mem [D];
  logic [AW-1:0] wptr;
  logic [AW-1:0] rptr;
  logic [AW:0]   count;
  wire           push = in_valid && in_ready;
  wire           pop  = out_valid && out_ready;

  assign in_ready  = count != (AW+1)'(D);
  assign out_valid = count != '0;
  assign out_data  = mem[rptr];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wptr] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wptr  <= '0;
      rptr  <= '0;
      count <= '0;
    end else begin
      wptr  <= push ? wptr + 1'b1 : wptr;
      rptr  <= pop ? rptr + 1'b1 : rptr;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

module ctas_top
  import ctas_pkg::*;
#(
  parameter int HDEPTH = HIST_DEPTH
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic             mode_wr,
  input  ctas_mode_e            mode_req,
  input  wire logic             ps_wr,
  input  wire logic [1:0]       ps_wdata,
  input  wire logic             trq_set,
  input  wire logic             trq_clr,
  input  wire logic [IDX_W-1:0] trq_idx,
  input  wire logic             trg_set,
  input  wire logic             trg_clr,
  input  wire logic [ABT_NBUF-1:0] rdy_flags,
  input  wire logic [NBUF-1:0]  frame_type,
  input  ctas_txev_s            txev,
  input  wire logic             tx_busy,
  input  wire logic             bus_idle,
  input  wire logic             rx_storing,
  input  wire logic             can_receive_pin,
  input  wire logic             hist_ready,
  output ctas_mode_e            op_mode,
  output logic [1:0]            power_save_field,
  output logic [NBUF-1:0]       tx_request_flag,
  output logic                  tx_status_flag,
  output logic                  block_tx_trigger,
  output logic [PTR_W-1:0]      block_ptr,
  output logic                  tx_start,
  output logic [IDX_W-1:0]      tx_start_idx,
  output logic                  tx_remote,
  output logic                  buffer_access_ok_flag,
  output logic                  clk_run,
  output logic                  hist_valid,
  output logic [IDX_W-1:0]      hist_idx
);
  initial begin
    if (HDEPTH < 2) begin
      $error("ctas_top: history depth too small");
    end
  end

  ctas_ps_e         st;
  ctas_ps_e         next_st;
  logic             sleep_pend;
  logic             init_pend;
  logic             clr_pend;
  logic             start_wait;
  logic             stage_full;
  logic             rx_s1;
  logic             rx_s2;
  logic             rx_d;
  logic [NBUF-1:0]  abort_mark;
  logic [NBUF-1:0]  ft_q;
  logic [NBUF-1:0]  next_trq;
  logic [IDX_W-1:0] sel;
  logic             f_in_ready;
  logic             f_out_valid;
  logic [IDX_W-1:0] f_out_data;

  // Command decode; all writes except power save are blocked unless awake
  wire awake     = st == S_AWAKE;
  wire busy_any  = tx_busy || start_wait;
  wire on_bus_w  = busy_any && tx_start_idx == trq_idx;
  wire clr_now   = awake && trq_clr && !on_bus_w;
  wire mark_set  = awake && trq_clr && on_bus_w;
  wire set_ok    = awake && trq_set;
  wire abt_mode  = op_mode == M_ABT;
  wire abt_bus   = busy_any && !tx_start_idx[IDX_W-1];
  wire abt_done  = txev.done && abt_mode && !txev.idx[IDX_W-1];
  wire [IDX_W-1:0] ptr_x = {1'b0, block_ptr};
  wire [PTR_W-1:0] ptr_inc = block_ptr + PTR_STEP;
  wire trg_go    = awake && abt_mode && trg_set && !block_tx_trigger;
  wire trg_stop  = awake && trg_clr && block_tx_trigger;
  wire abt_load  = block_tx_trigger && abt_mode && !clr_pend && !busy_any
                   && !tx_request_flag[ptr_x] && rdy_flags[block_ptr];
  wire abt_drop  = trg_stop && !abt_bus;
  wire trq_left  = next_trq[txev.idx];
  wire fall      = rx_d && !rx_s2;

  // Mode and sleep request decode
  wire init_now  = awake && mode_wr && mode_req == M_INIT;
  wire mode_now  = awake && mode_wr && mode_req != M_INIT;
  wire sleep_wr  = ps_wr && ps_wdata == PS_SLEEP;
  wire sleep_req = awake && sleep_wr;
  wire sleep_ok  = sleep_req && op_mode != M_INIT
                   && !init_pend && !init_now;
  // Storage in progress holds the request; a dominant bus holds it too
  wire enter     = sleep_pend && bus_idle && !rx_storing
                   && tx_request_flag == TRQ_NONE && !busy_any;
  wire wake      = st == S_SLEEP
                   && ((ps_wr && ps_wdata == PS_AWAKE) || fall);
  wire to_stop   = st == S_SLEEP && ps_wr && ps_wdata == PS_STOP;
  wire from_stop = st == S_STOP && sleep_wr;
  wire tx_mode   = op_mode != M_INIT && op_mode != M_RXONLY;
  // Stall on a full history FIFO so no completion is ever dropped
  wire can_start = awake && !busy_any && tx_request_flag != TRQ_NONE
                   && tx_mode && f_in_ready && !abt_load;
  wire f_push    = txev.done && txev.ok && !abt_done;
  wire f_pop     = f_out_valid && awake && (!stage_full || hist_ready);

  always_comb begin
    sel = '0;
    for (int i = NBUF - 1; i >= 0; i--) begin
      if (tx_request_flag[i]) begin
        sel = IDX_W'(i);
      end
    end
  end

  always_comb begin
    next_trq = tx_request_flag;
    if (set_ok) begin
      next_trq[trq_idx] = 1'b1;
    end
    if (abt_load) begin
      next_trq[ptr_x] = 1'b1;
    end
    if (abt_drop) begin
      next_trq[ptr_x] = 1'b0;
    end
    if (clr_now) begin
      next_trq[trq_idx] = 1'b0;
    end
    if (txev.done && (txev.ok || op_mode == M_SSHOT
                      || abort_mark[txev.idx])) begin
      next_trq[txev.idx] = 1'b0;
    end
  end

  always_comb begin
    next_st = st;
    unique case (st)
      S_AWAKE: begin
        if (enter) begin
          next_st = S_SLEEP;
        end
      end
      S_SLEEP: begin
        if (wake) begin
          next_st = S_AWAKE;
        end else if (to_stop) begin
          next_st = S_STOP;
        end
      end
      S_STOP: begin
        if (from_stop) begin
          next_st = S_SLEEP;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
      rx_d  <= 1'b1;
    end else begin
      rx_s1 <= can_receive_pin;
      rx_s2 <= rx_s1;
      rx_d  <= rx_s2;
    end
  end

  // Operating mode is untouched while asleep, so wake returns to it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      op_mode   <= M_INIT;
      init_pend <= 1'b0;
    end else begin
      // An initialization request with the bus free is taken at once
      if ((init_pend || init_now) && !busy_any) begin
        op_mode <= M_INIT;
      end else if (mode_now) begin
        op_mode <= mode_req;
      end
      init_pend <= (init_pend || init_now) && busy_any;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st                    <= S_AWAKE;
      sleep_pend            <= 1'b0;
      power_save_field      <= PS_AWAKE;
      buffer_access_ok_flag <= 1'b1;
      clk_run               <= 1'b1;
    end else begin
      st         <= next_st;
      sleep_pend <= (sleep_pend || sleep_ok) && !init_now && !enter;
      power_save_field      <= next_st == S_SLEEP ? PS_SLEEP :
                               next_st == S_STOP ? PS_STOP : PS_AWAKE;
      buffer_access_ok_flag <= next_st == S_AWAKE;
      clk_run               <= next_st == S_AWAKE;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_request_flag <= '0;
      abort_mark      <= '0;
      start_wait      <= 1'b0;
      tx_start        <= 1'b0;
      tx_start_idx    <= '0;
      tx_remote       <= 1'b0;
      tx_status_flag  <= 1'b0;
      ft_q            <= '0;
    end else begin
      tx_request_flag <= next_trq;
      abort_mark      <= (abort_mark | (mark_set ? NBUF'(1) << trq_idx : '0))
                         & ~(txev.done ? NBUF'(1) << txev.idx : '0);
      start_wait      <= can_start || (start_wait && !txev.done);
      tx_start        <= can_start;
      tx_start_idx    <= can_start ? sel : tx_start_idx;
      tx_remote       <= can_start ? frame_type[sel] : tx_remote;
      tx_status_flag  <= tx_busy;
      ft_q            <= frame_type;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      block_tx_trigger <= 1'b0;
      block_ptr        <= ABT_FIRST;
      clr_pend         <= 1'b0;
    end else begin
      if (abt_done && txev.ok && block_ptr == ABT_LAST) begin
        block_tx_trigger <= 1'b0;
        block_ptr        <= ABT_FIRST;
        clr_pend         <= 1'b0;
      end else if (abt_done && txev.ok) begin
        block_ptr        <= ptr_inc;
        block_tx_trigger <= block_tx_trigger && !clr_pend;
        clr_pend         <= 1'b0;
      end else if (abt_done && clr_pend) begin
        block_ptr        <= trq_left ? block_ptr : ptr_inc;
        block_tx_trigger <= 1'b0;
        clr_pend         <= 1'b0;
      end else if (trg_stop) begin
        block_tx_trigger <= abt_bus;
        clr_pend         <= abt_bus;
      end else if (trg_go) begin
        block_tx_trigger <= rdy_flags[block_ptr];
      end else if (block_tx_trigger && !busy_any && !clr_pend
                   && !tx_request_flag[ptr_x] && !rdy_flags[block_ptr]) begin
        block_tx_trigger <= 1'b0;
      end
    end
  end

  // History output stage; withheld while asleep
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stage_full <= 1'b0;
      hist_valid <= 1'b0;
      hist_idx   <= '0;
    end else begin
      stage_full <= f_pop || (stage_full && !(hist_valid && hist_ready));
      hist_valid <= (f_pop || (stage_full && !(hist_valid && hist_ready)))
                    && next_st == S_AWAKE;
      hist_idx   <= f_pop ? f_out_data : hist_idx;
    end
  end

  ctas_fifo #(
    .W (IDX_W),
    .D (HDEPTH)
  ) u_hist (
    .clk       (clk),
    .rstn      (rstn),
    .in_valid  (f_push),
    .in_ready  (f_in_ready),
    .in_data   (txev.idx),
    .out_valid (f_out_valid),
    .out_ready (f_pop),
    .out_data  (f_out_data)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  abort_clear_a: assert property (
    clr_now |=> !tx_request_flag[$past(trq_idx)])
    else $error("abort did not clear request flag");
  trig_hold_a: assert property (
    (trg_stop && abt_bus) |=> block_tx_trigger && clr_pend)
    else $error("trigger dropped during block frame");
  ptr_next_a: assert property (
    (abt_done && txev.ok && block_ptr != ABT_LAST)
    |=> block_ptr == $past(ptr_inc))
    else $error("pointer not advanced after success");
  ptr_err_a: assert property (
    (abt_done && !txev.ok && clr_pend)
    |=> block_ptr == ($past(trq_left) ? $past(block_ptr) : $past(ptr_inc))
        && !block_tx_trigger)
    else $error("pointer wrong after erroneous abort");
  last_done_a: assert property (
    (abt_done && txev.ok && block_ptr == ABT_LAST)
    |=> !block_tx_trigger && block_ptr == ABT_FIRST)
    else $error("buffer 7 completion not final");
  no_resume_a: assert property (
    (trg_go && !rdy_flags[block_ptr])
    |=> !block_tx_trigger && $stable(block_ptr))
    else $error("resumed with next buffer not ready");
  remote_sel_a: assert property (
    tx_start |-> tx_remote == ft_q[tx_start_idx])
    else $error("frame type not taken from config");
  sleep_notx_a: assert property (
    st != S_AWAKE |-> ##1 !tx_start [*2])
    else $error("transmission started while asleep");
  init_cancel_a: assert property (
    (sleep_req && (op_mode == M_INIT || init_pend || init_now))
    |=> !sleep_pend)
    else $error("sleep request not cancelled");
  pend_read_a: assert property (
    sleep_pend |-> power_save_field == PS_AWAKE)
    else $error("power save field not 00 while pending");
  enter_flags_a: assert property (
    enter |=> power_save_field == PS_SLEEP && !buffer_access_ok_flag
              && !clk_run)
    else $error("sleep entry flags wrong");
  mode_keep_a: assert property (
    st != S_AWAKE |=> $stable(op_mode))
    else $error("mode changed while asleep");
  edge_wake_a: assert property (
    (st == S_SLEEP && fall) |=> power_save_field == PS_AWAKE)
    else $error("no wake on receive falling edge");

  sleep_cycle_c: cover property (enter ##[1:50] wake);
  abt_last_c: cover property (abt_done && txev.ok && block_ptr == ABT_LAST);
  abort_err_c: cover property (clr_pend ##[1:50] (abt_done && !txev.ok));
  hist_full_c: cover property (!f_in_ready);
endmodule

// *** shared/ctas_pkg.sv ***
/*
  Constants and types for the CAN transmit abort and sleep control block.
  Assumes a single 250 MHz clock domain and 16 message buffers, of which
  buffers 0 to 7 form the automatic block transmit area.
*/
package ctas_pkg;

  localparam int          NBUF       = 16;
  localparam int          ABT_NBUF   = 8;
  localparam int          HIST_DEPTH = 32;
  localparam int          IDX_W      = 4;
  localparam int          PTR_W      = 3;
  localparam logic [2:0]  ABT_LAST   = 3'h7;
  localparam logic [2:0]  ABT_FIRST  = 3'h0;
  localparam logic [2:0]  PTR_STEP   = 3'h1;
  // Encodings of the two-bit power save field
  localparam logic [1:0]  PS_AWAKE   = 2'h0;
  localparam logic [1:0]  PS_SLEEP   = 2'h1;
  localparam logic [1:0]  PS_STOP    = 2'h3;
  localparam logic [15:0] TRQ_NONE   = 16'h0000;

  typedef enum logic [2:0] {
    M_INIT,
    M_NORMAL,
    M_ABT,
    M_RXONLY,
    M_SSHOT,
    M_STEST
  } ctas_mode_e;

  typedef enum logic [1:0] {
    S_AWAKE,
    S_SLEEP,
    S_STOP
  } ctas_ps_e;

  // Completion report from the protocol engine
  typedef struct packed {
    logic             done;
    logic             ok;
    logic [IDX_W-1:0] idx;
  } ctas_txev_s;

endpackage

// *** verification/ctas_bus_model.sv ***
/*
  Behavioural protocol engine and remote node for the abort and sleep block.
  Assumes tx_start is a one-cycle pulse; the bench picks the frame length
  (slow) and whether the frame ends in error (fail).
*/
`timescale 1ns/1ps

module ctas_bus_model
  import ctas_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic             tx_start,
  input  wire logic [IDX_W-1:0] tx_start_idx,
  input  wire logic             fail,
  input  wire logic             slow,
  output logic                  tx_busy,
  output logic                  bus_idle,
  output ctas_txev_s            txev
);
  logic [5:0]       cnt;
  logic [IDX_W-1:0] cur;

  // Idle as soon as no frame is on the bus (tx_busy low)
  assign bus_idle = !tx_busy;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_busy <= 1'b0;
      cnt     <= 6'h00;
      cur     <= 4'h0;
      txev    <= '0;
    end else begin
      txev.done <= 1'b0;
      // Index is not held after the pulse, so stale use shows up
      txev.idx  <= ~txev.idx;
      if (tx_start && !tx_busy) begin
        tx_busy <= 1'b1;
        cur     <= tx_start_idx;
        cnt     <= slow ? 6'h28 : 6'h06;
      end else if (tx_busy) begin
        if (cnt == 6'h00) begin
          tx_busy   <= 1'b0;
          txev.done <= 1'b1;
          txev.ok   <= !fail;
          txev.idx  <= cur;
        end else begin
          cnt <= cnt - 6'h01;
        end
      end
    end
  end
endmodule

// *** verification/ctas_top_tb.sv ***
/*
  Self-checking bench for ctas_top: aborts, block pointer and sleep.
  Assumes ctas_bus_model answers transmit starts; history entries are
  checked from a queue by a separate monitor.
*/
`timescale 1ns/1ps

module ctas_top_tb
  import ctas_pkg::*;
;
  logic                clk = 1'b0, rstn = 1'b0;
  logic                mode_wr = 1'b0, ps_wr = 1'b0;
  ctas_mode_e          mode_req = M_INIT;
  logic [1:0]          ps_wdata = 2'h0;
  logic                trq_set = 1'b0, trq_clr = 1'b0;
  logic [IDX_W-1:0]    trq_idx = 4'h0, i;
  logic                trg_set = 1'b0, trg_clr = 1'b0;
  logic [ABT_NBUF-1:0] rdy_flags = 8'hff;
  logic [NBUF-1:0]     frame_type = 16'h0000;
  logic                rx_storing = 1'b0, can_receive_pin = 1'b1;
  logic                hist_ready = 1'b0, fail = 1'b0, slow = 1'b0;
  logic                tx_busy, bus_idle, tx_status_flag, block_tx_trigger;
  ctas_txev_s          txev;
  ctas_mode_e          op_mode;
  logic [1:0]          power_save_field;
  logic [NBUF-1:0]     tx_request_flag;
  logic [PTR_W-1:0]    block_ptr;
  logic                tx_start, tx_remote, buffer_access_ok_flag, clk_run;
  logic [IDX_W-1:0]    tx_start_idx, hist_idx;
  logic                hist_valid;
  logic [IDX_W-1:0]    exp_q[$];
  int                  num_errors = 0, n_compared = 0, seed = 83;

  always #2 clk = ~clk;

  ctas_top #(.HDEPTH(2)) u_ctas_top (.clk(clk), .rstn(rstn),
    .mode_wr(mode_wr), .mode_req(mode_req), .ps_wr(ps_wr),
    .ps_wdata(ps_wdata), .trq_set(trq_set), .trq_clr(trq_clr),
    .trq_idx(trq_idx), .trg_set(trg_set), .trg_clr(trg_clr),
    .rdy_flags(rdy_flags), .frame_type(frame_type), .txev(txev),
    .tx_busy(tx_busy), .bus_idle(bus_idle), .rx_storing(rx_storing),
    .can_receive_pin(can_receive_pin), .hist_ready(hist_ready),
    .op_mode(op_mode), .power_save_field(power_save_field),
    .tx_request_flag(tx_request_flag), .tx_status_flag(tx_status_flag),
    .block_tx_trigger(block_tx_trigger), .block_ptr(block_ptr),
    .tx_start(tx_start), .tx_start_idx(tx_start_idx),
    .tx_remote(tx_remote), .buffer_access_ok_flag(buffer_access_ok_flag),
    .clk_run(clk_run), .hist_valid(hist_valid), .hist_idx(hist_idx));

  ctas_bus_model u_ctas_bus_model (.clk(clk), .rstn(rstn),
    .tx_start(tx_start), .tx_start_idx(tx_start_idx), .fail(fail),
    .slow(slow), .tx_busy(tx_busy), .bus_idle(bus_idle), .txev(txev));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string what);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic mode_w(input ctas_mode_e m);
    @(posedge clk); mode_wr <= 1'b1; mode_req <= m;
    @(posedge clk); mode_wr <= 1'b0;
  endtask

  task automatic ps_w(input logic [1:0] v);
    @(posedge clk); ps_wr <= 1'b1; ps_wdata <= v;
    @(posedge clk); ps_wr <= 1'b0;
  endtask

  task automatic trq_p(input logic s, input logic c, input logic [3:0] x);
    @(posedge clk); trq_set <= s; trq_clr <= c; trq_idx <= x;
    @(posedge clk); trq_set <= 1'b0; trq_clr <= 1'b0;
  endtask

  task automatic trg_p(input logic s, input logic c);
    @(posedge clk); trg_set <= s; trg_clr <= c;
    @(posedge clk); trg_set <= 1'b0; trg_clr <= 1'b0;
  endtask

  task automatic wait_start(output logic [IDX_W-1:0] x);
    int k;
    k = 0;
    do begin step(1); k++; end while (tx_start !== 1'b1 && k < 200);
    chk(16'(tx_start), 16'h0001, "transmit start seen");
    x = tx_start_idx;
  endtask

  task automatic wait_trg0();
    int k;
    k = 0;
    do begin step(1); k++; end while (block_tx_trigger !== 1'b0 && k < 900);
  endtask

  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Consumer stalls at random to back the history FIFO up
  always @(posedge clk) begin
    hist_ready <= 1'($random(seed));
    if (rstn && hist_valid === 1'b1 && hist_ready) begin
      if (exp_q.size() == 0) chk(16'(hist_idx), 16'hffff, "unexpected hist");
      else chk(16'(hist_idx), 16'(exp_q.pop_front()), "history entry");
    end
  end

  initial begin
    #(5000 * 4);
    num_errors++;
    $display("Error at %0t: watchdog expired", $time);
    end_of_test();
  end

  initial begin
    frame_type = 16'($random(seed));
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    // Receive-only never starts frames, so the abort is certain to win
    mode_w(M_RXONLY);
    trq_p(1'b1, 1'b0, 4'h3); step(1);
    chk(16'(tx_request_flag[3]), 16'h0001, "request set");
    trq_p(1'b0, 1'b1, 4'h3); step(1);
    chk(16'(tx_request_flag[3]), 16'h0000, "abort clears request");
    mode_w(M_NORMAL);
    trq_p(1'b1, 1'b0, 4'h5);
    exp_q.push_back(4'h5);
    wait_start(i);
    chk(16'(i), 16'h0005, "start index");
    chk(16'(tx_remote), 16'(frame_type[5]), "frame type");
    $display("test abort_and_remote done");

    step(20);
    mode_w(M_ABT);
    slow <= 1'b1;
    trg_p(1'b1, 1'b0);
    wait_start(i);
    trg_p(1'b0, 1'b1); step(1);
    chk(16'(block_tx_trigger), 16'h0001, "trigger held on bus");
    chk(16'(tx_status_flag), 16'h0001, "status while busy");
    wait_trg0();
    chk(16'(block_ptr), 16'(i + 4'h1), "pointer after ok abort");
    fail <= 1'b1;
    trg_p(1'b1, 1'b0);
    wait_start(i);
    trg_p(1'b0, 1'b1);
    wait_trg0();
    chk(16'(block_ptr), 16'(i), "pointer after error abort");
    // Trigger reads 0, so the leftover request may now be aborted
    trq_p(1'b0, 1'b1, 4'(i));
    step(60);
    fail <= 1'b0;
    slow <= 1'b0;
    step(2);
    rdy_flags <= ~(8'h01 << block_ptr);
    trg_p(1'b1, 1'b0); step(2);
    chk(16'(block_tx_trigger), 16'h0000, "not ready ends block");
    chk(16'(block_ptr), 16'(i), "pointer kept");
    rdy_flags <= 8'hff;
    trg_p(1'b1, 1'b0);
    wait_trg0();
    chk(16'(block_ptr), 16'h0000, "buffer 7 completes");
    $display("test block_transmit done");

    mode_w(M_NORMAL);
    for (int b = 0; b < 8; b++) trq_p(1'b0, 1'b1, 4'(b));
    step(30);
    rx_storing <= 1'b1;
    ps_w(2'h1); step(4);
    chk(16'(power_save_field), 16'h0000, "pending reads zero");
    rx_storing <= 1'b0;
    step(4);
    chk(16'(power_save_field), 16'h0001, "asleep reads one");
    chk(16'(buffer_access_ok_flag), 16'h0000, "buffers locked");
    chk(16'(clk_run), 16'h0000, "clock gated");
    trq_p(1'b1, 1'b0, 4'h2);
    mode_w(M_INIT); step(10);
    chk(16'(tx_request_flag[2]), 16'h0000, "request write blocked");
    chk(16'(tx_start), 16'h0000, "no start asleep");
    chk(16'(op_mode), 16'(M_NORMAL), "init ignored asleep");
    can_receive_pin <= 1'b0;
    step(6);
    can_receive_pin <= 1'b1;
    chk(16'(power_save_field), 16'h0000, "woken by pin");
    chk(16'(op_mode), 16'(M_NORMAL), "mode restored");
    step(30);
    ps_w(2'h1); step(4);
    ps_w(2'h0); step(2);
    chk(16'(power_save_field), 16'h0000, "woken by write");
    $display("test sleep done");

    mode_w(M_INIT); step(4);
    ps_w(2'h1); step(4);
    chk(16'(power_save_field), 16'h0000, "sleep refused in init");
    chk(16'(op_mode), 16'(M_INIT), "stays init");
    mode_w(M_NORMAL);
    @(posedge clk); ps_wr <= 1'b1; ps_wdata <= 2'h1;
    mode_wr <= 1'b1; mode_req <= M_INIT;
    @(posedge clk); ps_wr <= 1'b0; mode_wr <= 1'b0;
    step(6);
    chk(16'(power_save_field), 16'h0000, "init beats sleep");
    chk(16'(op_mode), 16'(M_INIT), "init taken");
    $display("test priority done");
    step(40);
    chk(16'(exp_q.size()), 16'h0000, "history drained");
    end_of_test();
  end
endmodule
